// [cwd_map.svh]
`ifndef CWD_MAP_SVH
`define CWD_MAP_SVH
// ****************************************************************
// Configuration memory addresses.
// ****************************************************************
`define CWD_ADDR_CFG1      16'h8007
`define CWD_ADDR_CFG2      16'h8008
`define CWD_ADDR_CAL1      16'h8009
`define CWD_ADDR_CAL2      16'h800A
// ****************************************************************
// Field positions.
// ****************************************************************
`define CWD_C1_FCM         13
`define CWD_C1_TWO_SPEED_SWITCHOVER_EN        12
`define CWD_C1_CLKOUT      11
`define CWD_C1_BOR_HI      10
`define CWD_C1_BOR_LO      9
`define CWD_C1_KEEP1       8
`define CWD_C1_CP          7
`define CWD_C1_RSTPIN      6
`define CWD_C1_POWERUP_TIMER_EN_N        5
`define CWD_C1_WDT_HI      4
`define CWD_C1_WDT_LO      3
`define CWD_C2_LVP         13
`define CWD_C2_DEBUG       12
`define CWD_C2_LOW_POWER_BROWNOUT_EN_N       11
`define CWD_C2_BROWNOUT_LEVEL_SEL        10
`define CWD_C2_STVR        9
// ****************************************************************
// Unimplemented bits read as one.
// ****************************************************************
`define CWD_C1_UNIMP_SMALL 14'h3104
`define CWD_C1_UNIMP_LARGE 14'h0100
`define CWD_C2_UNIMP_SMALL 14'h11FC
`define CWD_C2_UNIMP_LARGE 14'h01FC
`define CWD_ERASED_WORD    14'h3FFF
`endif

// [cwd_pkg.sv]
package cwd_pkg;
    typedef enum logic [1:0] {
        CWD_MODE_OFF = 2'h0,
        CWD_MODE_SW  = 2'h1,
        CWD_MODE_RUN = 2'h2,
        CWD_MODE_ON  = 2'h3
    } cwd_mode_t;
    typedef enum logic [3:0] {
        CWD_ST_IDLE  = 4'h1,
        CWD_ST_LOAD  = 4'h2,
        CWD_ST_RUN   = 4'h4,
        CWD_ST_ERASE = 4'h8
    } cwd_state_t;
endpackage : cwd_pkg

// [cwd_config_word_decoder.sv]
`timescale 1ns/100ps
`include "cwd_map.svh"
module cwd_config_word_decoder #(
    parameter bit          LARGE_PART = 1'b0,  // Three-bit oscillator layout
    parameter logic [15:0] PROG_WORDS = 16'h0800 // Program memory size in words
) (
    input  wire logic        clk,              // 20 MHz clock
    input  wire logic        reset_n,          // Synchronous reset, active low
    input  wire logic        nvWrEn,           // Programmer write strobe
    input  wire logic [15:0] nvAddr,           // Configuration address
    input  wire logic [13:0] nvWrData,         // Write data
    output logic      [13:0] nvRdData,         // Read data
    input  wire logic        bulkErase,        // Bulk erase request pulse
    input  wire logic        lvpEntered,       // Programming mode entered by low voltage
    input  wire logic [13:0] calInit1,         // Factory calibration word one
    input  wire logic [13:0] calInit2,         // Factory calibration word two
    input  wire logic        calLoad,          // Factory calibration load strobe
    output logic             progEraseReq,     // Pulse: erase all program memory
    output logic             decodeValid,      // Fields are latched
    output logic             clock_out_enable_n, // Low routes clock out
    output cwd_pkg::cwd_mode_t brownout_mode,  // Brown-out mode
    output logic             code_protect_n,   // Low protects program memory
    output logic             masterResetEn,    // Reset pin acts as master reset
    output logic             resetPinPullup,   // Weak pull-up forced on
    output logic             powerup_timer_en_n, // Low enables power-up timer
    output cwd_pkg::cwd_mode_t watchdog_mode,  // Watchdog mode
    output logic      [2:0]  osc_select,       // Oscillator selection code
    output logic             internal_osc,     // Internal oscillator selected
    output logic             fail_safe_clk_monitor_en, // Fail-safe monitor enable
    output logic             two_speed_switchover_en,  // Switchover enable
    output logic             low_voltage_prog_en,      // Low-voltage entry allowed
    output logic             debugPinsOwned,   // Programming pins owned by debugger
    output logic             low_power_brownout_en_n,  // Low enables low-power detector
    output logic             brownout_level_sel, // High selects lower level
    output logic             stack_fault_reset_en, // Reset on stack fault
    output logic             protectAll,       // Whole memory write-protected if PROG_WORDS is at most 0x1000, else words up to 0x0FFF
    output logic      [15:0] self_write_protect // Last protected address, 0 if none
);
    // ****************************************************************
    // Nonvolatile configuration words; calibration words reset to 0x3FFF.
    // ****************************************************************
    logic [13:0] cfg1_q;
    logic [13:0] cfg2_q;
    logic [13:0] cal1_q;
    logic [13:0] cal2_q;
    logic [13:0] unimp1;
    logic [13:0] unimp2;
    logic [13:0] cfg1Wr;
    logic [13:0] cfg2Wr;
    logic        cpRelease;
    cwd_pkg::cwd_state_t state_q;

    assign unimp1 = LARGE_PART ? `CWD_C1_UNIMP_LARGE : `CWD_C1_UNIMP_SMALL;
    assign unimp2 = LARGE_PART ? `CWD_C2_UNIMP_LARGE : `CWD_C2_UNIMP_SMALL;
    assign cfg1Wr = nvWrData | unimp1;
    // Clearing the low-voltage bit is refused while in low-voltage mode.
    assign cfg2Wr = (nvWrData | unimp2) |
                    (lvpEntered ? (14'h0001 << `CWD_C2_LVP) : 14'h0000);
    assign cpRelease = nvWrEn && (nvAddr == `CWD_ADDR_CFG1) &&
                       !cfg1_q[`CWD_C1_CP] && nvWrData[`CWD_C1_CP];

    // The configuration words are nonvolatile, so reset leaves them alone and the decode after reset sees them.
    always_ff @(posedge clk) begin
        if (nvWrEn && nvAddr == `CWD_ADDR_CFG1) begin
            cfg1_q <= cfg1Wr;
        end else if (nvWrEn && nvAddr == `CWD_ADDR_CFG2) begin
            cfg2_q <= cfg2Wr;
        end else if (bulkErase) begin
            cfg1_q <= `CWD_ERASED_WORD;
            cfg2_q <= `CWD_ERASED_WORD;
        end
    end

    // Calibration words ignore erase so factory trim is kept.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cal1_q <= `CWD_ERASED_WORD;
            cal2_q <= `CWD_ERASED_WORD;
        end else if (calLoad) begin
            cal1_q <= calInit1;
            cal2_q <= calInit2;
        end else if (nvWrEn && nvAddr == `CWD_ADDR_CAL1) begin
            cal1_q <= nvWrData;
        end else if (nvWrEn && nvAddr == `CWD_ADDR_CAL2) begin
            cal2_q <= nvWrData;
        end
    end

    always_comb begin
        case (nvAddr)
            `CWD_ADDR_CFG1: nvRdData = cfg1_q;
            `CWD_ADDR_CFG2: nvRdData = cfg2_q;
            `CWD_ADDR_CAL1: nvRdData = cal1_q;
            `CWD_ADDR_CAL2: nvRdData = cal2_q;
            default:        nvRdData = `CWD_ERASED_WORD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            progEraseReq <= 1'b0;
        end else begin
            progEraseReq <= cpRelease;
        end
    end

    // ****************************************************************
    // Latch sequencing.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= cwd_pkg::CWD_ST_IDLE;
        end else begin
            case (state_q)
                cwd_pkg::CWD_ST_IDLE:  state_q <= cwd_pkg::CWD_ST_LOAD;
                cwd_pkg::CWD_ST_LOAD:  state_q <= cwd_pkg::CWD_ST_RUN;
                cwd_pkg::CWD_ST_RUN:   state_q <= cpRelease ? cwd_pkg::CWD_ST_ERASE : cwd_pkg::CWD_ST_RUN;
                cwd_pkg::CWD_ST_ERASE: state_q <= cwd_pkg::CWD_ST_RUN;
                default:               state_q <= cwd_pkg::CWD_ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Decoded fields, held until next reset.
    // ****************************************************************
    logic [1:0]  wrtCode;
    logic [15:0] limit;
    always_comb begin
        wrtCode = cfg2_q[1:0];
        limit   = 16'h0000;
        case (wrtCode)
            2'h3: limit = 16'h0000;
            2'h2: limit = (PROG_WORDS <= 16'h0400) ? 16'h00FF : 16'h01FF;
            2'h1: begin
                if (PROG_WORDS <= 16'h0400)      limit = 16'h01FF;
                else if (PROG_WORDS <= 16'h0800) limit = 16'h03FF;
                else                             limit = 16'h07FF;
                if (PROG_WORDS > 16'h1000)       limit = 16'h0FFF;
            end
            2'h0: limit = (PROG_WORDS > 16'h1000) ? 16'h0FFF : PROG_WORDS - 16'h0001;
            default: limit = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            decodeValid              <= 1'b0;
            clock_out_enable_n       <= 1'b1;
            brownout_mode            <= cwd_pkg::CWD_MODE_ON;
            code_protect_n           <= 1'b1;
            masterResetEn            <= 1'b1;
            resetPinPullup           <= 1'b1;
            powerup_timer_en_n       <= 1'b1;
            watchdog_mode            <= cwd_pkg::CWD_MODE_ON;
            osc_select               <= 3'h7;
            internal_osc             <= 1'b0;
            fail_safe_clk_monitor_en <= 1'b0;
            two_speed_switchover_en  <= 1'b0;
            low_voltage_prog_en      <= 1'b1;
            debugPinsOwned           <= 1'b0;
            low_power_brownout_en_n  <= 1'b1;
            brownout_level_sel       <= 1'b1;
            stack_fault_reset_en     <= 1'b1;
            protectAll               <= 1'b0;
            self_write_protect       <= 16'h0000;
        end else if (state_q == cwd_pkg::CWD_ST_LOAD) begin
            decodeValid        <= 1'b1;
            clock_out_enable_n <= cfg1_q[`CWD_C1_CLKOUT];
            brownout_mode      <= cwd_pkg::cwd_mode_t'(cfg1_q[`CWD_C1_BOR_HI:`CWD_C1_BOR_LO]);
            code_protect_n     <= cfg1_q[`CWD_C1_CP];
            masterResetEn      <= cfg2_q[`CWD_C2_LVP] | cfg1_q[`CWD_C1_RSTPIN];
            resetPinPullup     <= cfg2_q[`CWD_C2_LVP] | cfg1_q[`CWD_C1_RSTPIN];
            powerup_timer_en_n <= cfg1_q[`CWD_C1_POWERUP_TIMER_EN_N];
            watchdog_mode      <= cwd_pkg::cwd_mode_t'(cfg1_q[`CWD_C1_WDT_HI:`CWD_C1_WDT_LO]);
            osc_select         <= LARGE_PART ? cfg1_q[2:0] : {1'b0, cfg1_q[1:0]};
            internal_osc       <= LARGE_PART ? (cfg1_q[2:0] == 3'h4) : (cfg1_q[1:0] == 2'h0);
            fail_safe_clk_monitor_en <= LARGE_PART & cfg1_q[`CWD_C1_FCM];
            two_speed_switchover_en  <= LARGE_PART & cfg1_q[`CWD_C1_TWO_SPEED_SWITCHOVER_EN];
            low_voltage_prog_en      <= cfg2_q[`CWD_C2_LVP];
            debugPinsOwned           <= LARGE_PART & ~cfg2_q[`CWD_C2_DEBUG];
            low_power_brownout_en_n  <= cfg2_q[`CWD_C2_LOW_POWER_BROWNOUT_EN_N];
            brownout_level_sel       <= cfg2_q[`CWD_C2_BROWNOUT_LEVEL_SEL];
            stack_fault_reset_en     <= cfg2_q[`CWD_C2_STVR];
            protectAll               <= (wrtCode == 2'h0);
            self_write_protect       <= limit;
        end
    end
endmodule : cwd_config_word_decoder

// [cwd_config_word_decoder_props.sv]
`timescale 1ns/100ps
// ************************************************************
// Checker for the decoder ports.
// ************************************************************
module cwd_config_word_decoder_props #(
    parameter logic [15:0] PROG_WORDS = 16'h0800 // Program memory size in words
) (
    input wire logic               clk,                // Clock
    input wire logic               reset_n,            // Reset, active low
    input wire logic               nvWrEn,             // Write strobe
    input wire logic        [15:0] nvAddr,             // Address
    input wire logic        [13:0] nvWrData,           // Write data
    input wire logic        [13:0] nvRdData,           // Read data
    input wire logic               lvpEntered,         // Low-voltage entry
    input wire logic               progEraseReq,       // Erase pulse
    input wire logic               decodeValid,        // Fields latched
    input cwd_pkg::cwd_mode_t      brownout_mode,      // Brown-out mode
    input wire logic               masterResetEn,      // Master reset
    input wire logic               resetPinPullup,     // Pull-up forced
    input wire logic               low_voltage_prog_en, // Low-voltage entry allowed
    input wire logic        [2:0]  osc_select,         // Oscillator code
    input wire logic               internal_osc,       // Internal oscillator
    input wire logic               protectAll,         // All protected, or up to 0x0FFF above 0x1000 words
    input wire logic        [15:0] self_write_protect  // Protection limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_erase_cause: assert property (nvWrEn && nvAddr == 16'h8007 && nvWrData[7] && !nvRdData[7] |=> progEraseReq)
        else $error("erase pulse missing after protection turned off");
    chk_erase_only: assert property (progEraseReq |-> $past(nvWrEn && nvAddr == 16'h8007 && nvWrData[7] && !nvRdData[7]))
        else $error("erase pulse without cause");
    chk_decode_rise: assert property ($rose(reset_n) |-> ##[1:2] decodeValid)
        else $error("decode not latched after reset");
    chk_decode_hold: assert property (decodeValid |=> decodeValid && $stable(brownout_mode) && $stable(osc_select)
        && $stable(self_write_protect))
        else $error("decoded fields changed before reset");
    chk_lvp_pin: assert property (decodeValid && low_voltage_prog_en |-> masterResetEn && resetPinPullup)
        else $error("reset pin not master reset with low-voltage entry");
    chk_unimp_one: assert property (nvAddr == 16'h8007 |-> (nvRdData & 14'h3104) == 14'h3104)
        else $error("word one unimplemented bit reads zero");
    chk_unimp_two: assert property (nvAddr == 16'h8008 |-> (nvRdData & 14'h11FC) == 14'h11FC)
        else $error("word two unimplemented bit reads zero");
    chk_lvp_keep: assert property (nvWrEn && nvAddr == 16'h8008 && lvpEntered ##1 nvAddr == 16'h8008 |-> nvRdData[13])
        else $error("low-voltage bit cleared in low-voltage mode");
    chk_protect_all: assert property (protectAll |-> self_write_protect == PROG_WORDS - 16'h0001)
        else $error("full protection limit wrong");
    chk_osc_small: assert property (decodeValid |-> !osc_select[2] && internal_osc == (osc_select == 3'h0))
        else $error("small part oscillator decode wrong");
endmodule : cwd_config_word_decoder_props

bind cwd_config_word_decoder cwd_config_word_decoder_props #(.PROG_WORDS(PROG_WORDS)) i_props (.clk, .reset_n,
    .nvWrEn, .nvAddr, .nvWrData, .nvRdData, .lvpEntered, .progEraseReq, .decodeValid, .brownout_mode, .masterResetEn,
    .resetPinPullup, .low_voltage_prog_en, .osc_select, .internal_osc, .protectAll, .self_write_protect);

// [cwd_config_word_decoder_test.sv]
`timescale 1ns/100ps
// ************************************************************
// Decoder testbench, small part with 2K words.
// ************************************************************
module cwd_config_word_decoder_test;
    logic clk = 1'b0, reset_n = 1'b0, nvWrEn = 1'b0, bulkErase = 1'b1, lvpEntered = 1'b0, calLoad = 1'b0;
    logic [15:0] nvAddr = 16'h8007;
    logic [13:0] nvWrData = 14'h0000, calInit1 = 14'h0000, calInit2 = 14'h0000, nvRdData, c1, c2;
    logic progEraseReq, decodeValid, clock_out_enable_n, code_protect_n, masterResetEn, resetPinPullup;
    logic powerup_timer_en_n, internal_osc, fail_safe_clk_monitor_en, two_speed_switchover_en, low_voltage_prog_en;
    logic debugPinsOwned, low_power_brownout_en_n, brownout_level_sel, stack_fault_reset_en, protectAll;
    cwd_pkg::cwd_mode_t brownout_mode, watchdog_mode;
    logic [2:0]  osc_select;
    logic [15:0] self_write_protect;
    logic [15:0] lim [4] = '{16'h07FF, 16'h03FF, 16'h01FF, 16'h0000};
    int nMismatch = 0, testsRun = 0, i;
    always #25 clk = ~clk;
    cwd_config_word_decoder i_dut (.clk, .reset_n, .nvWrEn, .nvAddr, .nvWrData, .nvRdData, .bulkErase, .lvpEntered,
        .calInit1, .calInit2, .calLoad, .progEraseReq, .decodeValid, .clock_out_enable_n, .brownout_mode,
        .code_protect_n, .masterResetEn, .resetPinPullup, .powerup_timer_en_n, .watchdog_mode, .osc_select,
        .internal_osc, .fail_safe_clk_monitor_en, .two_speed_switchover_en, .low_voltage_prog_en, .debugPinsOwned,
        .low_power_brownout_en_n, .brownout_level_sel, .stack_fault_reset_en, .protectAll, .self_write_protect);
    task stop_test;
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        testsRun++;
        if (g !== e) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [13:0] d);
        nvAddr = a;
        nvWrData = d;
        nvWrEn = 1'b1;
        @(negedge clk);
    endtask : wr
    // The write strobe stays up between writes and is dropped when a read moves the address.
    task rd(input logic [15:0] a, input logic [15:0] e, input string n);
        nvWrEn = 1'b0;
        nvAddr = a;
        #1;
        chk(n, e, {2'b00, nvRdData});
    endtask : rd
    // The decode must come up within a few cycles of reset release.
    task rst(input int n);
        int k;
        reset_n = 1'b0;
        repeat (n) @(negedge clk);
        reset_n = 1'b1;
        for (k = 0; k < 5 && decodeValid !== 1'b1; k++) @(negedge clk);
        if (decodeValid !== 1'b1) begin
            nMismatch++;
            $display("ERROR decodeValid expected 1 seen %b", decodeValid);
            stop_test();
        end
    endtask : rst
    initial begin
        @(negedge clk);
        bulkErase = 1'b0;
        rst(20);
        chk("brownout_mode", cwd_pkg::CWD_MODE_ON, brownout_mode);
        rd(16'h8007, 16'h3FFF, "word one erased");
        rd(16'h8006, 16'h3FFF, "unmapped read");
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            c1 = {2'b00, i[0], i[1:0], 1'b0, i[1], i[0], i[1], ~i[1:0], 1'b0, i[1:0]};
            c2 = {i[1], 1'b0, i[0], i[1], i[0], 7'h00, i[1:0]};
            wr(16'h8007, c1);
            wr(16'h8008, c2);
            rd(16'h8007, {2'b00, c1 | 14'h3104}, "word one");
            rd(16'h8008, {2'b00, c2 | 14'h11FC}, "word two");
            rst(2);
            chk("brownout_mode", i, brownout_mode);
            chk("watchdog_mode", 3 - i, watchdog_mode);
            chk("osc_select", i, osc_select);
            chk("internal_osc", i == 0, internal_osc);
            chk("clock_out_enable_n", i[0], clock_out_enable_n);
            chk("code_protect_n", i[1], code_protect_n);
            chk("masterResetEn", i[1] | i[0], masterResetEn);
            chk("resetPinPullup", i[1] | i[0], resetPinPullup);
            chk("powerup_timer_en_n", i[1], powerup_timer_en_n);
            chk("low_voltage_prog_en", i[1], low_voltage_prog_en);
            chk("low_power_brownout_en_n", i[0], low_power_brownout_en_n);
            chk("brownout_level_sel", i[1], brownout_level_sel);
            chk("stack_fault_reset_en", i[0], stack_fault_reset_en);
            chk("self_write_protect", lim[i], self_write_protect);
            chk("protectAll", i == 0, protectAll);
            chk("fail_safe_clk_monitor_en", 1'b0, fail_safe_clk_monitor_en);
            chk("two_speed_switchover_en", 1'b0, two_speed_switchover_en);
            chk("debugPinsOwned", 1'b0, debugPinsOwned);
            $display("decode test %0d done", i);
        end
        wr(16'h8007, 14'h3F7F);
        chk("progEraseReq", 1'b0, progEraseReq);
        wr(16'h8007, 14'h3FFF);
        chk("progEraseReq", 1'b1, progEraseReq);
        @(negedge clk);
        chk("progEraseReq", 1'b0, progEraseReq);
        $display("erase test done");
        lvpEntered = 1'b1;
        wr(16'h8008, 14'h0000);
        rd(16'h8008, 16'h31FC, "word two in low-voltage mode");
        lvpEntered = 1'b0;
        wr(16'h8008, 14'h0000);
        rd(16'h8008, 16'h11FC, "word two in high-voltage mode");
        $display("low-voltage test done");
        calInit1 = 14'h1234; calInit2 = 14'h0567; calLoad = 1'b1;
        @(negedge clk);
        calLoad = 1'b0;
        rd(16'h8009, 16'h1234, "calibration one");
        rd(16'h800A, 16'h0567, "calibration two");
        bulkErase = 1'b1;
        @(negedge clk);
        bulkErase = 1'b0;
        rd(16'h8009, 16'h1234, "calibration one after erase");
        rd(16'h800A, 16'h0567, "calibration two after erase");
        rd(16'h8008, 16'h3FFF, "word two after erase");
        $display("calibration test done");
        stop_test();
    end
endmodule : cwd_config_word_decoder_test
